// file: src/calibration_control_regs.sv
// Calibration control register bank with AXI4-Lite slave and sequencing
`timescale 1ns/100ps
`include "calib_consts.svh"
module calibration_control_regs (
    input  wire logic          clk,
    input  wire logic          resetn,
    // AXI4-Lite write address
    input  wire calib_pkg::bus_addr_t awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    // AXI4-Lite write data
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    // AXI4-Lite write response
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    // AXI4-Lite read address
    input  wire calib_pkg::bus_addr_t araddr,
    input  wire logic          arvalid,
    output logic               arready,
    // AXI4-Lite read data
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // Device context and engine events
    input  wire logic          single_channel_mode,
    input  wire logic          hardware_trigger_pin,
    input  wire logic          fault_flag,
    input  wire logic          foreground_complete_flag_event,
    input  wire logic          bg_stopped_event,
    input  wire logic          bg_resumed_event,
    // Routing outputs
    output logic               chan_a_from_b,
    output logic               chan_b_from_b,
    // Calibration control outputs
    output logic               calib_hold,
    output logic               divider_reset,
    output logic               calib_values_clear,
    output logic               foreground_active,
    output logic               background_active,
    output logic               offset_filter_enable,
    output logic               background_offset_enable,
    output logic               foreground_offset_enable,
    output logic               calib_status_pin,
    output logic               calib_trigger
);
    import calib_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg_byte_t  input_routing;
    reg_byte_t  calibration_run;
    reg_byte_t  calibration_config;
    reg_byte_t  calibration_pin_setup;
    reg_byte_t  software_trigger;
    reg_byte_t  calibration_state;

    // Bus holding registers
    bus_addr_t  wr_addr;
    logic [7:0] wr_byte;
    logic       wr_lane;
    logic       write_go;
    logic       wr_mapped;
    logic       wr_hit_routing;
    logic       wr_hit_run;
    logic       wr_hit_config;
    logic       wr_hit_pin;
    logic       wr_hit_trigger;
    logic       wr_hit_state;
    logic [7:0] rd_value;
    logic       rd_mapped;

    // Sequencing and status
    cal_state_t cal_state;
    cal_state_t next_cal_state;
    logic       cal_enable;
    logic       fg_enable;
    logic       bg_enable;
    logic       fg_complete;
    logic       cal_stopped;
    logic       fg_set;
    logic       stopped_set;
    logic       stopped_clear;
    logic [1:0] single_sel;
    logic       single_b;
    logic       next_chan_a_from_b;
    logic       next_chan_b_from_b;
    logic       next_status_pin;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------

    // Address accepted once, held until the response is taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awready <= 1'b1;
            wr_addr <= 12'h000;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            wr_addr <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Data accepted independently of the address
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wready  <= 1'b1;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
        end else if (wvalid && wready) begin
            wready  <= 1'b0;
            wr_byte <= wdata[7:0];
            wr_lane <= wstrb[0];
        end else if (bvalid && bready) begin
            wready  <= 1'b1;
        end
    end

    // Both halves held and no response pending
    assign write_go = !awready && !wready && !bvalid;

    // Write address decode on word boundaries
    always_comb begin
        wr_hit_routing = ({wr_addr[11:2], 2'b00} == `ADDR_INPUT_ROUTING);
        wr_hit_run     = ({wr_addr[11:2], 2'b00} == `ADDR_CALIBRATION_RUN);
        wr_hit_config  = ({wr_addr[11:2], 2'b00} == `ADDR_CALIBRATION_CONFIG);
        wr_hit_pin     = ({wr_addr[11:2], 2'b00} == `ADDR_CALIBRATION_PIN);
        wr_hit_trigger = ({wr_addr[11:2], 2'b00} == `ADDR_SOFTWARE_TRIGGER);
        wr_hit_state   = ({wr_addr[11:2], 2'b00} == `ADDR_CALIBRATION_STATE);
        wr_mapped      = wr_hit_routing || wr_hit_run || wr_hit_config
                         || wr_hit_pin || wr_hit_trigger || wr_hit_state;
    end

    // Write response, error for unmapped addresses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (write_go) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    // Routing register, reserved bits kept as written
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_routing <= `RST_INPUT_ROUTING;
        end else if (write_go && wr_lane && wr_hit_routing) begin
            input_routing <= wr_byte;
        end
    end

    // Calibration enable register, reset value runs calibration
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calibration_run <= `RST_CALIBRATION_RUN;
        end else if (write_go && wr_lane && wr_hit_run) begin
            calibration_run <= wr_byte;
        end
    end

    // Configuration register, software keeps enable low while writing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calibration_config <= `RST_CALIBRATION_CONFIG;
        end else if (write_go && wr_lane && wr_hit_config) begin
            calibration_config <= wr_byte;
        end
    end

    // Status pin and trigger source setup
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calibration_pin_setup <= `RST_CALIBRATION_PIN;
        end else if (write_go && wr_lane && wr_hit_pin) begin
            calibration_pin_setup <= wr_byte;
        end
    end

    // Software trigger, resets high so trigger idles high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            software_trigger <= `RST_SOFTWARE_TRIGGER;
        end else if (write_go && wr_lane && wr_hit_trigger) begin
            software_trigger <= wr_byte;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------

    // Read decode, unmapped words read zero
    always_comb begin
        rd_mapped = 1'b1;
        unique case ({araddr[11:2], 2'b00})
            `ADDR_INPUT_ROUTING:      rd_value = input_routing;
            `ADDR_CALIBRATION_RUN:    rd_value = calibration_run;
            `ADDR_CALIBRATION_CONFIG: rd_value = calibration_config;
            `ADDR_CALIBRATION_STATE:  rd_value = calibration_state;
            `ADDR_CALIBRATION_PIN:    rd_value = calibration_pin_setup;
            `ADDR_SOFTWARE_TRIGGER:   rd_value = software_trigger;
            default: begin
                rd_value  = 8'h00;
                rd_mapped = 1'b0;
            end
        endcase
    end

    // Read address taken, data returned on the next edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_value};
            rresp   <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Calibration sequencing
    // ------------------------------------------------------------
    assign cal_enable = calibration_run[`BIT_CAL_ENABLE];
    assign fg_enable  = calibration_config[`BIT_FG_CALIB];
    assign bg_enable  = calibration_config[`BIT_BG_CALIB];

    // Sequence: hold, start, foreground, background
    always_comb begin
        next_cal_state = cal_state;
        unique case (cal_state)
            CAL_HOLD:  next_cal_state = CAL_START;
            CAL_START: next_cal_state = fg_enable ? CAL_FORE : CAL_BACK;
            CAL_FORE:  next_cal_state = foreground_complete_flag_event ? CAL_BACK : CAL_FORE;
            CAL_BACK:  next_cal_state = CAL_BACK;
            default:   next_cal_state = CAL_HOLD;
        endcase
        if (!cal_enable) begin
            next_cal_state = CAL_HOLD;
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cal_state <= CAL_HOLD;
        end else begin
            cal_state <= next_cal_state;
        end
    end

    // Hold and divider reset follow the enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calib_hold    <= 1'b1;
            divider_reset <= 1'b1;
        end else begin
            calib_hold    <= !cal_enable;
            divider_reset <= !cal_enable;
        end
    end

    // Stored values cleared on every start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calib_values_clear <= 1'b0;
        end else begin
            calib_values_clear <= (cal_state == CAL_START);
        end
    end

    // Engine phase strobes and effective configuration
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            foreground_active        <= 1'b0;
            background_active        <= 1'b0;
            offset_filter_enable     <= 1'b0;
            background_offset_enable <= 1'b0;
            foreground_offset_enable <= 1'b0;
        end else begin
            foreground_active        <= (cal_state == CAL_FORE);
            background_active        <= (cal_state == CAL_BACK) && bg_enable;
            offset_filter_enable     <= calibration_config[`BIT_OFFSET_FILTER];
            background_offset_enable <= calibration_config[`BIT_BG_OFFSET] && bg_enable;
            foreground_offset_enable <= calibration_config[`BIT_FG_OFFSET] && fg_enable;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------

    // Flag set and clear conditions
    always_comb begin
        fg_set        = (cal_state == CAL_FORE) && foreground_complete_flag_event;
        stopped_set   = ((cal_state == CAL_BACK) && bg_enable && bg_stopped_event)
                        || (!bg_enable && fg_set)
                        || (!bg_enable && (cal_state == CAL_START) && !fg_enable);
        stopped_clear = !cal_enable
                        || ((cal_state == CAL_BACK) && bg_enable && bg_resumed_event);
    end

    // Foreground complete flag
    status_flag u_fg_flag (
        .clk    (clk),
        .resetn (resetn),
        .set    (fg_set),
        .clear  (!cal_enable),
        .flag   (fg_complete)
    );

    // Calibration stopped flag
    status_flag u_stop_flag (
        .clk    (clk),
        .resetn (resetn),
        .set    (stopped_set),
        .clear  (stopped_clear),
        .flag   (cal_stopped)
    );

    // Read-only status, reserved bits zero
    assign calibration_state = {6'h00, cal_stopped, fg_complete};

    // ------------------------------------------------------------
    // Input routing
    // ------------------------------------------------------------
    assign single_sel = input_routing[1:0];
    assign single_b   = (single_sel == `SINGLE_SEL_B);

    // Single mode uses the field, dual mode the swap bit
    always_comb begin
        if (single_channel_mode) begin
            next_chan_a_from_b = single_b;
            next_chan_b_from_b = single_b;
        end else begin
            next_chan_a_from_b = input_routing[`BIT_DUAL_SWAP];
            next_chan_b_from_b = !input_routing[`BIT_DUAL_SWAP];
        end
    end

    // Routing outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_a_from_b <= 1'b0;
            chan_b_from_b <= 1'b1;
        end else begin
            chan_a_from_b <= next_chan_a_from_b;
            chan_b_from_b <= next_chan_b_from_b;
        end
    end

    // ------------------------------------------------------------
    // Status pin and trigger
    // ------------------------------------------------------------

    // Status pin source select, reserved and code 3 low
    always_comb begin
        unique case (calibration_pin_setup[2:1])
            `STATUS_SEL_FOREGROUND_COMPLETE_FLAG: next_status_pin = fg_complete;
            `STATUS_SEL_FAULT:   next_status_pin = fault_flag;
            default:             next_status_pin = 1'b0;
        endcase
    end

    // Pin and trigger outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calib_status_pin <= 1'b0;
            calib_trigger    <= 1'b1;
        end else begin
            calib_status_pin <= next_status_pin;
            calib_trigger    <= calibration_pin_setup[`BIT_TRIG_SOURCE]
                                ? hardware_trigger_pin
                                : software_trigger[`BIT_SOFT_TRIG];
        end
    end

endmodule : calibration_control_regs

// file: src/calib_consts.svh
// Register map constants for the calibration control register bank
// Function
// - Dual-channel swap bit 0 routes A-to-A, B-to-B; 1 exchanges; ignored single-channel.
// - Single-channel input field: 1 selects input A, 2 input B; 0, 3 reserved.
// - Calibration enable high runs calibration; low holds it in reset; resets to 1.
// - Calibration enable low also resets the digital and serial link clock dividers.
// - Clear enable before changing guarded settings; setting it again reruns calibration.
// - Configuration bit 4 high applies offset filtering; resets to 0.
// - Configuration bit 3 enables background offset calibration, only with background enabled.
// - Configuration bit 2 enables foreground offset calibration, only with foreground enabled.
// - Configuration bit 1 enables background calibration; resets to 0.
// - Start always clears stored values; bit 0 at 1 runs foreground, at 0 skips.
// - Stopped bit reads 1 once background calibration halts; 0 when it resumes.
// - With background disabled, stopped sets when foreground completes or is skipped.
// - Foreground-complete bit goes high when foreground calibration finishes; both read-only.
// - Status pin selector: 0 foreground-complete, 1 reserved, 2 fault flag, 3 low.
// - Trigger source 0 uses software bit, pin ignored; 1 uses pin, bit ignored.
// - Software bit stands in for the pin; source 0, bit 1 keeps trigger high.
`ifndef CALIB_CONSTS_SVH
`define CALIB_CONSTS_SVH

// ------------------------------------------------------------
// Register indices and byte addresses
// ------------------------------------------------------------
`define IDX_INPUT_ROUTING       8'h60
`define IDX_CALIBRATION_RUN     8'h61
`define IDX_CALIBRATION_CONFIG  8'h62
`define IDX_CALIBRATION_STATE   8'h6a
`define IDX_CALIBRATION_PIN     8'h6b
`define IDX_SOFTWARE_TRIGGER    8'h6c
`define ADDR_INPUT_ROUTING      {2'b00, `IDX_INPUT_ROUTING, 2'b00}
`define ADDR_CALIBRATION_RUN    {2'b00, `IDX_CALIBRATION_RUN, 2'b00}
`define ADDR_CALIBRATION_CONFIG {2'b00, `IDX_CALIBRATION_CONFIG, 2'b00}
`define ADDR_CALIBRATION_STATE  {2'b00, `IDX_CALIBRATION_STATE, 2'b00}
`define ADDR_CALIBRATION_PIN    {2'b00, `IDX_CALIBRATION_PIN, 2'b00}
`define ADDR_SOFTWARE_TRIGGER   {2'b00, `IDX_SOFTWARE_TRIGGER, 2'b00}

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_INPUT_ROUTING       8'h01
`define RST_CALIBRATION_RUN     8'h01
`define RST_CALIBRATION_CONFIG  8'h01
`define RST_CALIBRATION_PIN     8'h00
`define RST_SOFTWARE_TRIGGER    8'h01

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define BIT_DUAL_SWAP           4
`define BIT_CAL_ENABLE          0
`define BIT_OFFSET_FILTER       4
`define BIT_BG_OFFSET           3
`define BIT_FG_OFFSET           2
`define BIT_BG_CALIB            1
`define BIT_FG_CALIB            0
`define BIT_TRIG_SOURCE         0
`define BIT_SOFT_TRIG           0
`define SINGLE_SEL_A            2'h1
`define SINGLE_SEL_B            2'h2
`define STATUS_SEL_FOREGROUND_COMPLETE_FLAG      2'h0
`define STATUS_SEL_FAULT        2'h2
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// file: src/calib_pkg.sv
// Types shared by the calibration control register bank
package calib_pkg;

    // Calibration sequencing states, one-hot
    typedef enum logic [3:0] {
        CAL_HOLD  = 4'b0001,
        CAL_START = 4'b0010,
        CAL_FORE  = 4'b0100,
        CAL_BACK  = 4'b1000
    } cal_state_t;

    typedef logic [7:0]  reg_byte_t;
    typedef logic [11:0] bus_addr_t;

endpackage : calib_pkg

// file: src/status_flag.sv
// Sticky status flag with set taking priority over clear
`timescale 1ns/100ps
module status_flag (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);

    // Set wins so an event in a clearing cycle is kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end

endmodule : status_flag

// file: dv/calibration_control_regs_props.sv
// Checker of bus timing and calibration sequencing
`timescale 1ns/100ps
module calibration_control_regs_props (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        foreground_complete_flag_event,
    input wire logic        calib_hold,
    input wire logic        divider_reset,
    input wire logic        calib_values_clear,
    input wire logic        foreground_active,
    input wire logic        background_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    hold_divider_a: assert property (calib_hold == divider_reset)
        else $error("divider reset mismatch");
    hold_idle_a: assert property (calib_hold [*2] |-> !foreground_active && !background_active)
        else $error("active while held");
    start_clear_a: assert property ($fell(calib_hold) |=> calib_values_clear)
        else $error("no clear at start");
    clear_pulse_a: assert property (calib_values_clear |=> !calib_values_clear)
        else $error("clear too long");
    fg_finish_a: assert property (foreground_active && foreground_complete_flag_event |-> ##2 !foreground_active)
        else $error("foreground kept on");
    write_resp_a: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid)
        else $error("write response late");
    write_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write stuck");
    read_resp_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read response late");
    read_done_a: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read stuck");
    rdata_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("rdata upper bits");
endmodule : calibration_control_regs_props

bind calibration_control_regs calibration_control_regs_props u_props (
    .clk, .resetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rdata,
    .rvalid, .rready, .foreground_complete_flag_event, .calib_hold, .divider_reset, .calib_values_clear, .foreground_active,
    .background_active
);

// file: dv/calibration_control_regs_bench.sv
// Self-checking bench for the calibration control register bank
`timescale 1ns/100ps
`include "calib_consts.svh"
module calibration_control_regs_bench;
    import calib_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, single_channel_mode = 1'b0, hardware_trigger_pin = 1'b0, fault_flag = 1'b0;
    logic foreground_complete_flag_event = 1'b0, bg_stopped_event = 1'b0, bg_resumed_event = 1'b0;
    bus_addr_t   awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, chan_a_from_b, chan_b_from_b, calib_hold;
    logic        divider_reset, calib_values_clear, foreground_active, background_active, offset_filter_enable;
    logic        background_offset_enable, foreground_offset_enable, calib_status_pin, calib_trigger, seen = 1'b0;
    logic [10:0] tbl [7] = '{11'h035, 11'h04a, 11'h009, 11'h44b, 11'h404, 11'h400, 11'h40c};
    int          fail_count = 0, n_compared = 0, cycles = 0;

    calibration_control_regs u_dut (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .single_channel_mode, .hardware_trigger_pin, .fault_flag, .foreground_complete_flag_event, .bg_stopped_event,
        .bg_resumed_event, .chan_a_from_b, .chan_b_from_b, .calib_hold, .divider_reset, .calib_values_clear,
        .foreground_active, .background_active, .offset_filter_enable, .background_offset_enable,
        .foreground_offset_enable, .calib_status_pin, .calib_trigger);

    // Clock and hang watchdog
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (++cycles == 5000) begin
            fail_count++;
            results();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic results;
        if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic wr(input bus_addr_t a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr

    task automatic rd(input string n, input bus_addr_t a, input logic [7:0] e, input logic [1:0] er = 2'h0);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(n, {24'h0, e}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task automatic pulse(input int k);
        @(posedge clk);
        {foreground_complete_flag_event, bg_stopped_event, bg_resumed_event} <= 3'h4 >> k;
        @(posedge clk);
        {foreground_complete_flag_event, bg_stopped_event, bg_resumed_event} <= 3'h0;
        settle();
    endtask : pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd("routing", `ADDR_INPUT_ROUTING, 8'h01);
        rd("run", `ADDR_CALIBRATION_RUN, 8'h01);
        rd("config", `ADDR_CALIBRATION_CONFIG, 8'h01);
        rd("pin", `ADDR_CALIBRATION_PIN, 8'h00);
        rd("soft", `ADDR_SOFTWARE_TRIGGER, 8'h01);
        chk("trigger", 32'h1, {31'h0, calib_trigger});
        wr(`ADDR_SOFTWARE_TRIGGER, 8'hfe);
        rd("soft", `ADDR_SOFTWARE_TRIGGER, 8'hfe);
        chk("trigger", 32'h0, {31'h0, calib_trigger});
        wr(`ADDR_SOFTWARE_TRIGGER, 8'h01);
        wstrb <= 4'he;
        wr(`ADDR_CALIBRATION_PIN, 8'h06);
        wstrb <= 4'hf;
        rd("pin", `ADDR_CALIBRATION_PIN, 8'h00);
        wr(12'h1b4, 8'h55, 2'h2);
        rd("unmapped", 12'h1b4, 8'h00, 2'h2);
        wr(`ADDR_CALIBRATION_STATE, 8'hff);
        rd("status", `ADDR_CALIBRATION_STATE, 8'h00);
    endtask : t_regs

    task automatic t_routing;
        for (int i = 0; i < 7; i++) begin
            single_channel_mode <= tbl[i][10];
            wr(`ADDR_INPUT_ROUTING, tbl[i][9:2]);
            settle();
            chk("chan_a", {31'h0, tbl[i][1]}, {31'h0, chan_a_from_b});
            chk("chan_b", {31'h0, tbl[i][0]}, {31'h0, chan_b_from_b});
        end
        single_channel_mode <= 1'b0;
    endtask : t_routing

    task automatic t_calib;
        wr(`ADDR_CALIBRATION_RUN, 8'h00);
        wr(`ADDR_CALIBRATION_CONFIG, 8'h0c);
        wr(`ADDR_CALIBRATION_RUN, 8'h01);
        settle();
        chk("fg_active", 32'h0, {31'h0, foreground_active});
        chk("offsets", 32'h0, {30'h0, background_offset_enable, foreground_offset_enable});
        rd("status", `ADDR_CALIBRATION_STATE, 8'h02);
        wr(`ADDR_CALIBRATION_RUN, 8'h00);
        settle();
        chk("hold", 32'h3, {30'h0, calib_hold, divider_reset});
        rd("status", `ADDR_CALIBRATION_STATE, 8'h00);
        wr(`ADDR_CALIBRATION_CONFIG, 8'h1f);
        rd("config", `ADDR_CALIBRATION_CONFIG, 8'h1f);
        wr(`ADDR_CALIBRATION_RUN, 8'h01);
        repeat (6) @(posedge clk) if (calib_values_clear === 1'b1) seen = 1'b1;
        chk("clear", 32'h1, {31'h0, seen});
        chk("fg_active", 32'h1, {31'h0, foreground_active});
        chk("offsets", 32'h7, {29'h0, offset_filter_enable, background_offset_enable,
            foreground_offset_enable});
        pulse(0);
        rd("status", `ADDR_CALIBRATION_STATE, 8'h01);
        chk("bg_active", 32'h1, {31'h0, background_active});
        pulse(1);
        rd("status", `ADDR_CALIBRATION_STATE, 8'h03);
        pulse(2);
        rd("status", `ADDR_CALIBRATION_STATE, 8'h01);
    endtask : t_calib

    task automatic t_pin;
        for (int c = 0; c < 8; c++) begin
            fault_flag <= c[0];
            wr(`ADDR_CALIBRATION_PIN, {5'h0, c[2:1], 1'b0});
            settle();
            chk("status_pin", {31'h0, c[2:1] == 2'h0 || (c[2:1] == 2'h2 && c[0])},
                {31'h0, calib_status_pin});
        end
        wr(`ADDR_CALIBRATION_PIN, 8'h01);
        for (int f = 0; f < 2; f++) begin
            hardware_trigger_pin <= f[0];
            settle();
            chk("trigger", {31'h0, f[0]}, {31'h0, calib_trigger});
        end
    endtask : t_pin

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_routing();
        t_calib();
        t_pin();
        results();
    end
endmodule : calibration_control_regs_bench
